// File: test/rhi_host_model.sv
/*
  Controller-side bus master that makes byte accesses to the radio host
  interface. It assumes a single clock and a bench that calls acc only
  after reset has been released.
*/
`timescale 1ns/10ps
module rhi_host_model (
  input wire logic ref_clk_i,
  input wire logic cpu_wait_i,
  input wire logic [7:0] cpu_rdata_i,
  output logic [7:0] cpu_addr_o,
  output logic cpu_rd_o,
  output logic cpu_wr_o,
  output logic [7:0] cpu_wdata_o
);
  // The bus idles from time zero so that reset never sees a strobe.
  initial begin
    cpu_addr_o = 8'h00;
    cpu_rd_o = 1'b0;
    cpu_wr_o = 1'b0;
    cpu_wdata_o = 8'h00;
  end
  // One access, held until an edge sees no stall; the strobe is dropped
  // right after that edge, because holding it would start a second access.
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q, output int nw);
    nw = 0;
    @(posedge ref_clk_i);
    #1;
    cpu_addr_o = a;
    cpu_rd_o = !w;
    cpu_wr_o = w;
    cpu_wdata_o = d;
    // The stall is combinational from the strobe, so let it settle before looking.
    #1;
    // The bound keeps a stuck stall from hanging the run.
    while (cpu_wait_i === 1'b1 && nw < 16) begin
      @(posedge ref_clk_i);
      #1;
      nw++;
    end
    @(posedge ref_clk_i);
    #1;
    cpu_rd_o = 1'b0;
    cpu_wr_o = 1'b0;
    cpu_wdata_o = ~d;
    q = cpu_rdata_i;
  endtask
endmodule // rhi_host_model

// File: test/rhi_top_bench.sv
/*
  Self-checking bench of the radio host interface: bus, frame buffer,
  trigger bit, soft reset and interrupt flags.
  It assumes the host model above and the design package.
*/
`timescale 1ns/10ps
module rhi_top_bench;
  import rhi_pkg::*;
  logic ref_clk_i = 1'b0, nrst_i = 1'b0, ce_i = 1'b1, cpu_rd_i, cpu_wr_i, cpu_wait_o;
  logic [7:0] cpu_addr_i, cpu_wdata_i, cpu_rdata_o, irq_req_o, tx_data_o;
  logic radio_clk_run_i = 1'b1, tx_busy_i = 1'b0, rx_wr_i = 1'b0, rx_len_we_i = 1'b0;
  logic rx_lqi_we_i = 1'b0, tx_rd_i = 1'b0, irq_any_o, pa_off_o, radio_rst_o;
  logic tx_start_o, aret_start_o, sleep_o, wake_o, alt_hold_o;
  logic [7:0] irq_evt_i = 8'h00, irq_ack_i = 8'h00, rx_data_i = 8'h00;
  logic [7:0] rx_len_i = 8'h00, rx_lqi_i = 8'h00, q;
  logic [6:0] rx_addr_i = 7'h00, tx_addr_i = 7'h00, irq_vec_o;
  rhi_radio_state_e radio_state_i = RHI_ST_CLOCK_ONLY;
  int errors = 0;
  int n_tests = 0;
  int nw;
  // The clock toggles every half period of 2.5 ns.
  always #2.5 ref_clk_i = ~ref_clk_i;
  rhi_host_model host_u (.ref_clk_i, .cpu_wait_i(cpu_wait_o), .cpu_rdata_i(cpu_rdata_o),
    .cpu_addr_o(cpu_addr_i), .cpu_rd_o(cpu_rd_i), .cpu_wr_o(cpu_wr_i),
    .cpu_wdata_o(cpu_wdata_i));
  rhi_top #(.WAIT_CYCLES(3)) dut_u (.ref_clk_i, .nrst_i, .ce_i, .cpu_addr_i, .cpu_rd_i,
    .cpu_wr_i, .cpu_wdata_i, .cpu_rdata_o, .cpu_wait_o, .radio_clk_run_i, .radio_state_i,
    .tx_busy_i, .irq_evt_i, .irq_ack_i, .irq_req_o, .irq_vec_o, .irq_any_o, .pa_off_o,
    .radio_rst_o, .tx_start_o, .aret_start_o, .sleep_o, .wake_o, .alt_hold_o, .rx_wr_i,
    .rx_addr_i, .rx_data_i, .rx_len_we_i, .rx_len_i, .rx_lqi_we_i, .rx_lqi_i, .tx_rd_i,
    .tx_addr_i, .tx_data_o);
  // Compares with case inequality so that an unknown never matches.
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.acc(1'b1, a, d, q, nw);
  endtask
  task automatic rd(input logic [7:0] a);
    host_u.acc(1'b0, a, 8'h00, q, nw);
  endtask
  // Advances one cycle and lands just past the edge, where outputs settle.
  task automatic step();
    @(posedge ref_clk_i);
    #1;
  endtask
  // Reset values, stall counts and an unmapped address.
  task automatic t_reset();
    chk("irq_req", 8'h00, irq_req_o);
    rd(RHI_ADDR_IRQ_EN);
    chk("irq_en", RHI_IRQ_EN_RST, q);
    chk("reg_waits", 8'd3, nw[7:0]);
    rd(RHI_ADDR_FB_FIRST);
    chk("buf_waits", 8'd0, nw[7:0]);
    rd(8'h10);
    chk("unmapped", 8'h00, q);
  endtask
  // With the radio clock stopped, radio registers read zero.
  task automatic t_noclk();
    wr(RHI_ADDR_IRQ_EN, 8'h81);
    radio_clk_run_i = 1'b0;
    rd(RHI_ADDR_IRQ_EN);
    chk("en_noclk", 8'h00, q);
    rd(RHI_ADDR_PIN_CTRL);
    chk("pin_waits", 8'd0, nw[7:0]);
    radio_clk_run_i = 1'b1;
    rd(RHI_ADDR_IRQ_EN);
    chk("en_clk", 8'h81, q);
    wr(RHI_ADDR_IRQ_EN, 8'h00);
  endtask
  // Transmit layout, then a received frame overwrites only what it writes.
  task automatic t_buf();
    wr(RHI_ADDR_FB_LAST, 8'ha5);
    wr(RHI_ADDR_FB_FIRST, 8'h07);
    rd(RHI_ADDR_FB_LAST);
    chk("buf_last", 8'ha5, q);
    tx_rd_i = 1'b1;
    step();
    tx_rd_i = 1'b0;
    chk("tx_len", 8'h07, tx_data_o);
    rx_wr_i = 1'b1;
    rx_data_i = 8'h5a;
    step();
    rx_wr_i = 1'b0;
    rx_len_we_i = 1'b1;
    rx_len_i = 8'h05;
    step();
    rx_len_we_i = 1'b0;
    rx_lqi_we_i = 1'b1;
    rx_lqi_i = 8'hc3;
    step();
    rx_lqi_we_i = 1'b0;
    rd(RHI_ADDR_FB_FIRST);
    chk("rx_byte0", 8'h5a, q);
    rd(8'h85);
    chk("rx_lqi", 8'hc3, q);
    rd(RHI_ADDR_RX_LEN);
    chk("rx_len", 8'h05, q);
    rd(RHI_ADDR_FB_LAST);
    chk("kept", 8'ha5, q);
  endtask
  // Pending flags, enables, priority, unlock during transmit, clearing.
  task automatic t_irq();
    wr(RHI_ADDR_IRQ_PEND, 8'hff);
    wr(RHI_ADDR_IRQ_EN, 8'h0a);
    irq_evt_i = 8'h09;
    step();
    irq_evt_i = 8'h00;
    chk("req", 8'h08, irq_req_o);
    chk("any", 8'h01, {7'h00, irq_any_o});
    step();
    chk("vec60", {1'b0, RHI_IRQ_VEC_BASE} + 8'd3, {1'b0, irq_vec_o});
    tx_busy_i = 1'b1;
    irq_evt_i = 8'h02;
    step();
    irq_evt_i = 8'h40;
    chk("pa_off", 8'h01, {7'h00, pa_off_o});
    step();
    irq_evt_i = 8'h00;
    tx_busy_i = 1'b0;
    chk("vec58", {1'b0, RHI_IRQ_VEC_BASE} + 8'd1, {1'b0, irq_vec_o});
    wr(RHI_ADDR_IRQ_PEND, 8'h02);
    rd(RHI_ADDR_IRQ_PEND);
    chk("pend", 8'h09, q);
    irq_ack_i = 8'h08;
    step();
    irq_ack_i = 8'h00;
    chk("acked", 8'h00, irq_req_o);
    chk("any_off", 8'h00, {7'h00, irq_any_o});
  endtask
  // Rising trigger in the synth-on, auto-retry, clock-only and listen states, wake on falling, levels ignored.
  task automatic t_trig();
    for (int i = 1; i < 4; i++) begin
      radio_state_i = rhi_radio_state_e'(i % 3);
      wr(RHI_ADDR_PIN_CTRL, 8'h00);
      wr(RHI_ADDR_PIN_CTRL, 8'h02);
      step();
      chk("action", 8'h04 >> (i - 1), {5'h00, tx_start_o, aret_start_o, sleep_o});
    end
    rd(RHI_ADDR_IRQ_EN);
    chk("en_asleep", 8'h00, q);
    radio_state_i = RHI_ST_SLEEP;
    wr(RHI_ADDR_PIN_CTRL, 8'h00);
    step();
    chk("wake", 8'h01, {7'h00, wake_o});
    radio_state_i = RHI_ST_SYNTH_ON;
    wr(RHI_ADDR_PIN_CTRL, 8'h02);
    wr(RHI_ADDR_PIN_CTRL, 8'h02);
    step();
    chk("no_restart", 8'h00, {7'h00, tx_start_o});
    rd(RHI_ADDR_PIN_CTRL);
    chk("trig_kept", 8'h02, q);
    wr(RHI_ADDR_PIN_CTRL, 8'h00);
    radio_state_i = RHI_ST_LISTEN;
    wr(RHI_ADDR_PIN_CTRL, 8'h02);
    step();
    chk("alt_held", 8'h01, {7'h00, alt_hold_o});
    wr(RHI_ADDR_PIN_CTRL, 8'h00);
    step();
    chk("alt_freed", 8'h00, {7'h00, alt_hold_o});
  endtask
  // Soft reset pulses once, clears itself and drops the enables.
  task automatic t_srst();
    int n;
    n = 0;
    wr(RHI_ADDR_IRQ_EN, 8'h01);
    wr(RHI_ADDR_PIN_CTRL, 8'h01);
    repeat (3) begin
      if (radio_rst_o === 1'b1) n++;
      step();
    end
    chk("rst_pulses", 8'd1, n[7:0]);
    rd(RHI_ADDR_PIN_CTRL);
    chk("rst_bit", 8'h00, q);
    rd(RHI_ADDR_IRQ_EN);
    chk("en_cleared", 8'h00, q);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Reset is held for three cycles, then the scenarios run in turn.
  initial begin
    repeat (3) @(posedge ref_clk_i);
    #1;
    nrst_i = 1'b1;
    t_reset();
    t_noclk();
    t_buf();
    t_irq();
    t_trig();
    t_srst();
    end_sim();
  end
  // The tests need well under a thousand cycles; this span is generous.
  initial begin
    #20000;
    errors++;
    end_sim();
  end
endmodule // rhi_top_bench

// File: verilog/rhi_frame_mem.sv
/*
  Two-port frame buffer memory with registered read data on both ports.
  Assumes both ports run on the same clock; a write on both ports to the
  same address in the same cycle leaves the radio port's byte.
*/
`timescale 1ns/10ps
module rhi_frame_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  input wire logic ref_clk_i,
  input wire logic ce_i,
  input wire logic a_en_i,
  input wire logic a_we_i,
  input wire logic [AW-1:0] a_addr_i,
  input wire logic [WIDTH-1:0] a_wdata_i,
  output logic [WIDTH-1:0] a_rdata_o,
  input wire logic b_en_i,
  input wire logic b_we_i,
  input wire logic [AW-1:0] b_addr_i,
  input wire logic [WIDTH-1:0] b_wdata_i,
  output logic [WIDTH-1:0] b_rdata_o
);

  // Storage has no reset, so bytes only change on a real write.
  logic [WIDTH-1:0] mem_q [DEPTH];

  // Write port order puts the radio port last so it wins a collision.
  always_ff @(posedge ref_clk_i) begin
    if (ce_i) begin
      if (a_en_i && a_we_i) begin
        mem_q[a_addr_i] <= a_wdata_i;
      end
      if (b_en_i && b_we_i) begin
        mem_q[b_addr_i] <= b_wdata_i;
      end
    end
  end

  // Read data leave through registers, one cycle after the strobe.
  always_ff @(posedge ref_clk_i) begin
    if (ce_i && a_en_i) begin
      a_rdata_o <= mem_q[a_addr_i];
    end
    if (ce_i && b_en_i) begin
      b_rdata_o <= mem_q[b_addr_i];
    end
  end

endmodule // rhi_frame_mem

// File: verilog/rhi_pkg.sv
/*
  Shared constants and types of the radio host interface: the controller
  I/O map, the pin control bit positions, the interrupt source order and the
  radio state codes reported by the radio core.
  Assumes a byte-wide controller I/O bus with an 8-bit address.
*/
package rhi_pkg;

  // Controller I/O map of the interface.
  localparam logic [7:0] RHI_ADDR_PIN_CTRL = 8'h00;    // Pin control, controller domain.
  localparam logic [7:0] RHI_ADDR_IRQ_PEND = 8'h01;    // Pending flags, write one to clear.
  localparam logic [7:0] RHI_ADDR_IRQ_EN = 8'h02;      // Interrupt enables.
  localparam logic [7:0] RHI_ADDR_RX_LEN = 8'h03;      // Received frame length.
  localparam logic [7:0] RHI_ADDR_FB_FIRST = 8'h80;    // First frame buffer byte.
  localparam logic [7:0] RHI_ADDR_FB_LAST = 8'hff;     // Last frame buffer byte.
  localparam int RHI_FB_SEL_BIT = 7;                   // Address bit that selects the buffer.

  // Pin control register fields.
  localparam int RHI_PIN_RST_BIT = 0;                  // Radio soft reset bit.
  localparam int RHI_PIN_TRIG_BIT = 1;                 // Sleep or transmit trigger bit.

  // Reset values.
  localparam logic [7:0] RHI_PIN_CTRL_RST = 8'h00;
  localparam logic [7:0] RHI_IRQ_PEND_RST = 8'h00;
  localparam logic [7:0] RHI_IRQ_EN_RST = 8'h00;
  localparam logic [7:0] RHI_RX_LEN_RST = 8'h00;

  // Frame buffer geometry.
  localparam int RHI_FB_DEPTH = 128;
  localparam int RHI_FB_AW = 7;

  // Interrupt sources, index 0 has the highest priority.
  localparam int RHI_IRQ_LOCK = 0;
  localparam int RHI_IRQ_UNLOCK = 1;
  localparam int RHI_IRQ_RX_START = 2;
  localparam int RHI_IRQ_RX_END = 3;
  localparam int RHI_IRQ_MEAS_DONE = 4;
  localparam int RHI_IRQ_ADDR_MATCH = 5;
  localparam int RHI_IRQ_TX_END = 6;
  localparam int RHI_IRQ_AWAKE = 7;
  localparam logic [6:0] RHI_IRQ_VEC_BASE = 7'h39;     // Vector number of source 0.

  // Wait cycles on radio register accesses for a radio clock near 16 MHz.
  localparam int RHI_WAIT_CYCLES = 3;
  localparam int RHI_RADIO_CLK_MHZ = 16;
  localparam int RHI_REF_CLK_MHZ = 200;

  // Radio core state as reported to the interface.
  typedef enum logic [2:0] {
    RHI_ST_CLOCK_ONLY,
    RHI_ST_SYNTH_ON,
    RHI_ST_AUTO_RETRY,
    RHI_ST_LISTEN,
    RHI_ST_AUTO_ACK_LISTEN,
    RHI_ST_SLEEP,
    RHI_ST_BUSY
  } rhi_radio_state_e;

endpackage

// File: verilog/rhi_top.sv
/*
  Radio host interface: controller I/O port with wait cycles for radio
  registers, the shared frame buffer, the pin control register with radio
  soft reset and the trigger bit, and the eight-source interrupt logic.
  Assumes the radio core runs on ref_clk_i, reports its state, events and
  clock status as synchronous signals, and that the controller holds an
  access stable while cpu_wait_o is high.
*/
`timescale 1ns/10ps
module rhi_top #(
  parameter int WAIT_CYCLES = rhi_pkg::RHI_WAIT_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic [7:0] cpu_addr_i,
  input wire logic cpu_rd_i,
  input wire logic cpu_wr_i,
  input wire logic [7:0] cpu_wdata_i,
  output logic [7:0] cpu_rdata_o,
  output logic cpu_wait_o,
  input wire logic radio_clk_run_i,
  input wire rhi_pkg::rhi_radio_state_e radio_state_i,
  input wire logic tx_busy_i,
  input wire logic [7:0] irq_evt_i,
  input wire logic [7:0] irq_ack_i,
  output logic [7:0] irq_req_o,
  output logic [6:0] irq_vec_o,
  output logic irq_any_o,
  output logic pa_off_o,
  output logic radio_rst_o,
  output logic tx_start_o,
  output logic aret_start_o,
  output logic sleep_o,
  output logic wake_o,
  output logic alt_hold_o,
  input wire logic rx_wr_i,
  input wire logic [6:0] rx_addr_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_len_we_i,
  input wire logic [7:0] rx_len_i,
  input wire logic rx_lqi_we_i,
  input wire logic [7:0] rx_lqi_i,
  input wire logic tx_rd_i,
  input wire logic [6:0] tx_addr_i,
  output logic [7:0] tx_data_o
);
  import rhi_pkg::*;

  // Counter width covers any sensible wait count.
  localparam int WCW = 4;

  // Address decode helper, used for every register select.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
    hit = (a == ref_a);
  endfunction

  // Decode wires of the controller port.
  wire cpu_acc = cpu_rd_i | cpu_wr_i;                       // Any access strobe.
  wire fb_sel = cpu_addr_i[RHI_FB_SEL_BIT];                 // Frame buffer window.
  wire pin_sel = ~fb_sel & hit(cpu_addr_i, RHI_ADDR_PIN_CTRL);
  wire pend_sel = ~fb_sel & hit(cpu_addr_i, RHI_ADDR_IRQ_PEND);
  wire en_sel = ~fb_sel & hit(cpu_addr_i, RHI_ADDR_IRQ_EN);
  wire len_sel = ~fb_sel & hit(cpu_addr_i, RHI_ADDR_RX_LEN);
  wire rreg_acc = cpu_acc & ~fb_sel & ~pin_sel;             // Radio register access.

  // State registers.
  logic [WCW-1:0] wait_cnt_q;        // Wait cycles spent on the current access.
  logic trig_q;                      // Sleep or transmit trigger level.
  logic trig_prev_q;                 // Trigger level one enabled cycle ago.
  logic radio_rst_q;                 // One-cycle radio reset pulse.
  logic [7:0] irq_pend_q;            // Latched interrupt events.
  logic [7:0] irq_en_q;              // Interrupt enables.
  logic [7:0] rx_len_q;              // Length of the last received frame.
  logic suppress_q;                  // End events blocked after an unlock.
  logic tx_start_q;
  logic aret_start_q;
  logic wake_q;
  logic sleep_q;                     // Sleep held from the clock-only state.
  logic alt_q;                       // Listen-state change held by the trigger.
  logic fb_rd_q;                     // Last completed read came from the buffer.
  logic [7:0] reg_rdata_q;           // Read data of a register access.
  logic [6:0] irq_vec_q;

  // A wait counter that restarts on every new access, so accesses may follow back to back.
  wire wait_done = (wait_cnt_q == WCW'(WAIT_CYCLES));
  wire rreg_done = rreg_acc & wait_done;                    // Register access completes.
  assign cpu_wait_o = rreg_acc & ~wait_done;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wait_cnt_q <= '0;
    end else if (ce_i) begin
      wait_cnt_q <= (rreg_acc && !wait_done) ? wait_cnt_q + 1'b1 : '0;
    end
  end

  // Radio registers only answer while the radio clock runs and it is awake.
  wire radio_on = radio_clk_run_i & ~sleep_q;
  wire rreg_wr = rreg_done & cpu_wr_i & radio_on;
  wire pin_wr = cpu_acc & cpu_wr_i & pin_sel;

  // Pin control: the reset bit is a pulse, the trigger bit is kept as written.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      trig_q <= RHI_PIN_CTRL_RST[RHI_PIN_TRIG_BIT];
      radio_rst_q <= RHI_PIN_CTRL_RST[RHI_PIN_RST_BIT];
      trig_prev_q <= 1'b0;
    end else if (ce_i) begin
      radio_rst_q <= pin_wr & cpu_wdata_i[RHI_PIN_RST_BIT];
      if (pin_wr) begin
        trig_q <= cpu_wdata_i[RHI_PIN_TRIG_BIT];
      end
      trig_prev_q <= trig_q;
    end
  end
  assign radio_rst_o = radio_rst_q;

  // Edges of the trigger bit; levels alone never start anything.
  wire trig_rise = trig_q & ~trig_prev_q;
  wire trig_fall = ~trig_q & trig_prev_q;

  // Trigger actions per radio state.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_start_q <= 1'b0;
      aret_start_q <= 1'b0;
      wake_q <= 1'b0;
      sleep_q <= 1'b0;
      alt_q <= 1'b0;
    end else if (ce_i) begin
      tx_start_q <= trig_rise & (radio_state_i == RHI_ST_SYNTH_ON);
      aret_start_q <= trig_rise & (radio_state_i == RHI_ST_AUTO_RETRY);
      wake_q <= trig_fall & sleep_q;
      if (radio_rst_q) begin
        sleep_q <= 1'b0;
        alt_q <= 1'b0;
      end else if (trig_rise) begin
        if (radio_state_i == RHI_ST_CLOCK_ONLY) begin
          sleep_q <= 1'b1;
        end
        if (radio_state_i == RHI_ST_LISTEN || radio_state_i == RHI_ST_AUTO_ACK_LISTEN) begin
          alt_q <= 1'b1;
        end
      end else if (trig_fall) begin
        sleep_q <= 1'b0;
        alt_q <= 1'b0;
      end
    end
  end
  assign tx_start_o = tx_start_q;
  assign aret_start_o = aret_start_q;
  assign wake_o = wake_q;
  assign sleep_o = sleep_q;
  assign alt_hold_o = alt_q;

  // Unlock while transmitting kills the amplifier at once and blocks the end event.
  wire unlock_in_tx = irq_evt_i[RHI_IRQ_UNLOCK] & tx_busy_i;
  wire block_end = unlock_in_tx | suppress_q;
  wire [7:0] evt_eff = irq_evt_i & ~(8'h01 << RHI_IRQ_TX_END & {8{block_end}});
  assign pa_off_o = block_end;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      suppress_q <= 1'b0;
    end else if (ce_i) begin
      suppress_q <= tx_busy_i & block_end;
    end
  end

  // Pending flags: a new event wins over a clear in the same cycle.
  wire [7:0] pend_w1c = {8{rreg_wr & pend_sel}} & cpu_wdata_i;
  wire [7:0] pend_clr = pend_w1c | irq_ack_i;
  wire [7:0] pend_d = (irq_pend_q & ~pend_clr) | evt_eff;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_pend_q <= RHI_IRQ_PEND_RST;
      irq_en_q <= RHI_IRQ_EN_RST;
      rx_len_q <= RHI_RX_LEN_RST;
    end else if (ce_i) begin
      if (radio_rst_q) begin
        irq_pend_q <= RHI_IRQ_PEND_RST;
        irq_en_q <= RHI_IRQ_EN_RST;
        rx_len_q <= RHI_RX_LEN_RST;
      end else begin
        irq_pend_q <= pend_d;
        if (rreg_wr && en_sel) begin
          irq_en_q <= cpu_wdata_i;
        end
        if (rx_len_we_i) begin
          rx_len_q <= rx_len_i;
        end
      end
    end
  end

  // Requests are gated by the enables; the vector names the most urgent one.
  wire [7:0] req_w = irq_pend_q & irq_en_q;
  assign irq_req_o = req_w;
  assign irq_any_o = |req_w;

  // Fixed priority: lowest source index, hence lowest vector, wins.
  logic [6:0] vec_d;
  always_comb begin
    vec_d = 7'h00;
    for (int i = 7; i >= 0; i--) begin
      if (req_w[i]) begin
        vec_d = RHI_IRQ_VEC_BASE + 7'(i);
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_vec_q <= 7'h00;
    end else if (ce_i) begin
      irq_vec_q <= vec_d;
    end
  end
  assign irq_vec_o = irq_vec_q;

  // Register read selection; radio registers read zero while the radio clock is off.
  wire [7:0] pin_rd = 8'h00 | (8'(trig_q) << RHI_PIN_TRIG_BIT);
  wire [7:0] rreg_rd = pend_sel ? irq_pend_q : en_sel ? irq_en_q : len_sel ? rx_len_q : 8'h00;
  wire [7:0] rreg_rd_g = radio_on ? rreg_rd : 8'h00;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_q <= 8'h00;
      fb_rd_q <= 1'b0;
    end else if (ce_i) begin
      if (cpu_rd_i && fb_sel) begin
        fb_rd_q <= 1'b1;
      end else if (cpu_rd_i && pin_sel) begin
        fb_rd_q <= 1'b0;
        reg_rdata_q <= pin_rd;
      end else if (cpu_rd_i && rreg_done) begin
        fb_rd_q <= 1'b0;
        reg_rdata_q <= rreg_rd_g;
      end
    end
  end

  // Frame buffer: controller on port A without waits, radio on port B.
  logic [7:0] fb_a_rdata;
  wire fb_a_en = cpu_acc & fb_sel;
  wire rx_any_wr = rx_wr_i | rx_lqi_we_i;
  wire [6:0] fb_b_addr = rx_lqi_we_i ? rx_len_q[6:0] : rx_wr_i ? rx_addr_i : tx_addr_i;
  wire [7:0] fb_b_wdata = rx_lqi_we_i ? rx_lqi_i : rx_data_i;

  rhi_frame_mem #(
    .WIDTH(8),
    .DEPTH(RHI_FB_DEPTH),
    .AW(RHI_FB_AW)
  ) u_fb (
    .ref_clk_i(ref_clk_i),
    .ce_i(ce_i),
    .a_en_i(fb_a_en),
    .a_we_i(cpu_wr_i),
    .a_addr_i(cpu_addr_i[6:0]),
    .a_wdata_i(cpu_wdata_i),
    .a_rdata_o(fb_a_rdata),
    .b_en_i(rx_any_wr | tx_rd_i),
    .b_we_i(rx_any_wr),
    .b_addr_i(fb_b_addr),
    .b_wdata_i(fb_b_wdata),
    .b_rdata_o(tx_data_o)
  );

  assign cpu_rdata_o = fb_rd_q ? fb_a_rdata : reg_rdata_q;

  // Helper: length of the wait phase of the current radio register access.
  logic [WCW-1:0] waited_q;
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      waited_q <= '0;
    end else if (ce_i) begin
      waited_q <= cpu_wait_o ? waited_q + 1'b1 : '0;
    end
  end

  property p_wait_len;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      (rreg_done && ce_i) |-> (waited_q == WCW'(WAIT_CYCLES));
  endproperty
  a_wait_len: assert property (p_wait_len) else $error("wrong wait count");

  property p_zero_read;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      (ce_i && cpu_rd_i && rreg_done && !radio_on) |=> (cpu_rdata_o == 8'h00);
  endproperty
  a_zero_read: assert property (p_zero_read) else $error("read not zero");

  property p_fb_nowait;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      (cpu_acc && fb_sel) |-> !cpu_wait_o;
  endproperty
  a_fb_nowait: assert property (p_fb_nowait) else $error("buffer waited");

  property p_rst_pulse;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      (ce_i && pin_wr && cpu_wdata_i[RHI_PIN_RST_BIT]) |=> radio_rst_o ##1 (!radio_rst_o || !ce_i);
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset not a pulse");

  property p_trig_keep;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      (!pin_wr) |=> (trig_q == $past(trig_q));
  endproperty
  a_trig_keep: assert property (p_trig_keep) else $error("trigger changed");

  property p_tx_start;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      (ce_i && trig_q && !trig_prev_q && radio_state_i == RHI_ST_SYNTH_ON) |=> tx_start_o;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("no transmit start");

  property p_edge_only;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      tx_start_o |-> $past(trig_q) && !$past(trig_prev_q);
  endproperty
  a_edge_only: assert property (p_edge_only) else $error("start without edge");

  property p_hold;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      (alt_q && ce_i && !trig_q && trig_prev_q && !radio_rst_q) |=> !alt_hold_o;
  endproperty
  a_hold: assert property (p_hold) else $error("hold not released");

  property p_req_gate;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      irq_req_o[RHI_IRQ_LOCK] |-> irq_en_q[RHI_IRQ_LOCK] && irq_pend_q[RHI_IRQ_LOCK];
  endproperty
  a_req_gate: assert property (p_req_gate) else $error("request not gated");

  property p_ack_clear;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      (ce_i && irq_ack_i[RHI_IRQ_AWAKE] && !irq_evt_i[RHI_IRQ_AWAKE]) |=> !irq_pend_q[RHI_IRQ_AWAKE];
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("ack did not clear");

  property p_w0_keep;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      (ce_i && irq_pend_q[RHI_IRQ_LOCK] && !radio_rst_q && !irq_ack_i[RHI_IRQ_LOCK]
       && !(rreg_wr && pend_sel && cpu_wdata_i[RHI_IRQ_LOCK])) |=> irq_pend_q[RHI_IRQ_LOCK];
  endproperty
  a_w0_keep: assert property (p_w0_keep) else $error("flag lost");

  property p_vec;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      (ce_i && req_w[RHI_IRQ_LOCK]) |=> (irq_vec_o == 7'h39);
  endproperty
  a_vec: assert property (p_vec) else $error("wrong vector");

  property p_unlock;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      unlock_in_tx |-> pa_off_o && !evt_eff[RHI_IRQ_TX_END];
  endproperty
  a_unlock: assert property (p_unlock) else $error("end not blocked");

  property p_en_reset;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      $rose(nrst_i) |-> (irq_en_q == 8'h00);
  endproperty
  a_en_reset: assert property (p_en_reset) else $error("enables not clear");

  c_tx: cover property (@(posedge ref_clk_i) disable iff (!nrst_i) tx_start_o);
  c_sleep_wake: cover property (@(posedge ref_clk_i) disable iff (!nrst_i) sleep_o ##[1:50] wake_o);
  c_wait: cover property (@(posedge ref_clk_i) disable iff (!nrst_i) cpu_wait_o ##1 !cpu_wait_o);
  c_irq: cover property (@(posedge ref_clk_i) disable iff (!nrst_i) irq_any_o);

endmodule // rhi_top
